// ===== drob_map.svh
// Constants for the detection report output buffer: sizes, field positions and timing counts.
// Assumes one 250 MHz clock and that interval timing strobes come from logic on that clock.
//
// Summary of operation
// - At interval start, the azimuth/prf header word is strobed into the first stage.
// - After the header, only report words with a crossing strobe are loaded.
// - The capture register is the first stage of a 40 by 32 shift register.
// - Each loaded report word pushes the earlier words one place down.
// - Header plus 38 reports fit; further reports are lost and set status bit 0.
// - At interval end a 1.3 MHz clock shifts words until the header reaches the end.
// - With the header at the output end, a data request pulse offers it.
// - Each acknowledge advances the output register one word and, except after the last word, issues another request.
// - Requests repeat until the output register is empty, then stop.
// - An interval ending before the output register is empty sets status bit 1.
// - The input register keeps collecting the next interval while the output drains.
// - Output data and request pulses also go to a test port, whose acknowledge is used only when the selector picks it.
// - A selector picks the acknowledge source; the processor computer is the normal setting.
// - Reports carry delayed magnitude, per-interval range-gate count and filter number 0 to 7.
// - The header carries both loss status bits of the previous interval.
`ifndef DROB_MAP_SVH
`define DROB_MAP_SVH

`define DROB_WORD_BITS 32
`define DROB_DEPTH 40
`define DROB_MAX_WORDS 39
`define DROB_FILTERS 8
`define DROB_AZ_BITS 12
`define DROB_PRF_BITS 2
`define DROB_RANGE_BITS 10
`define DROB_MAG_BITS 16
`define DROB_VEL_BITS 3
`define DROB_STAT_OVERFLOW 0
`define DROB_STAT_LATE 1
`define DROB_CLK_HZ 250000000
`define DROB_XFER_HZ 1300000
// Longest period that still keeps the rate at or above 1.3 MHz, rounded down.
`define DROB_XFER_DIV (`DROB_CLK_HZ / `DROB_XFER_HZ)

`endif

// ===== drob_pkg.sv
// Types for the detection report output buffer.
// Assumes drob_map.svh is on the include path.
`include "drob_map.svh"

package drob_pkg;

    typedef struct packed {
        logic [`DROB_WORD_BITS-`DROB_AZ_BITS-`DROB_PRF_BITS-3:0] spare;
        logic [1:0] lossStatus;
        logic [`DROB_PRF_BITS-1:0] prf;
        logic [`DROB_AZ_BITS-1:0] azimuth;
    } drob_header_s;

    typedef struct packed {
        logic [`DROB_WORD_BITS-`DROB_VEL_BITS-`DROB_RANGE_BITS-`DROB_MAG_BITS-1:0] spare;
        logic [`DROB_VEL_BITS-1:0] velocity;
        logic [`DROB_RANGE_BITS-1:0] range;
        logic [`DROB_MAG_BITS-1:0] strength;
    } drob_report_s;

    typedef enum logic [1:0] {
        DROB_IDLE,
        DROB_ALIGN,
        DROB_OFFER,
        DROB_WAIT
    } drob_drain_e;

endpackage

// ===== drob_rate_div.sv
// Divider giving a one-cycle enable at the transfer rate.
// Assumes the single system clock; the enable is used by the drain logic only.
`include "drob_map.svh"

module drob_rate_div #(
    parameter int DIV = `DROB_XFER_DIV
) (
    input wire logic clock,
    input wire logic rst_b,
    output logic tick
);

    logic [15:0] count;
    wire logic atEnd = (count == 16'(DIV - 1));

    // Free-running count; the tick phase is arbitrary with respect to interval end.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            count <= atEnd ? 16'h0000 : count + 16'h0001;
            tick <= atEnd;
        end
    end

endmodule

// ===== drob_buffer.sv
// Detection report output buffer: input shift register, output register and request handshake.
// Assumes interval, filter and crossing strobes come from logic on this clock; acknowledges
// and the source selector come from pins and are synchronised here.
`include "drob_map.svh"

module drob_buffer #(
    parameter int DEPTH = `DROB_DEPTH,
    parameter int MAX_WORDS = `DROB_MAX_WORDS,
    parameter int XFER_DIV = `DROB_XFER_DIV
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic intervalStart,
    input wire logic intervalEnd,
    input wire logic [`DROB_AZ_BITS-1:0] azimuth,
    input wire logic [`DROB_PRF_BITS-1:0] prf,
    input wire logic filterTick,
    input wire logic [`DROB_MAG_BITS-1:0] delayedMagnitude,
    input wire logic thresholdCrossingStrobe,
    input wire logic processorAck,
    input wire logic testAck,
    input wire logic ackFromTest,
    output logic [`DROB_WORD_BITS-1:0] outputWord,
    output logic inputDataRequest,
    output logic [`DROB_WORD_BITS-1:0] testWord,
    output logic testDataRequest,
    output logic overflowStatus,
    output logic lateStatus,
    output logic draining
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and acknowledge selection.

    logic [1:0] procSync;
    logic [1:0] testSync;
    logic [1:0] selSync;
    logic ackLast;
    // Selection after the second flop; a switch moved mid-frame while the two acknowledges differ can fake an edge.
    // ack source select
    wire logic ackNow = selSync[1] ? testSync[1] : procSync[1];
    wire logic ackRise = ackNow && !ackLast;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            procSync <= 2'h0;
            testSync <= 2'h0;
            selSync <= 2'h0;
            ackLast <= 1'b0;
        end else begin
            procSync <= {procSync[0], processorAck};
            testSync <= {testSync[0], testAck};
            selSync <= {selSync[0], ackFromTest};
            ackLast <= ackNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Report fields: filter number and range-gate count.

    logic [`DROB_VEL_BITS-1:0] filterNum;
    logic [`DROB_RANGE_BITS-1:0] rangeGate;
    wire logic gateDone = filterTick && (filterNum == `DROB_VEL_BITS'(`DROB_FILTERS - 1));

    always_ff @(posedge clock) begin
        if (!rst_b || intervalStart) begin
            filterNum <= '0;
            rangeGate <= '0;
        end else if (filterTick) begin
            filterNum <= filterNum + `DROB_VEL_BITS'(1);
            if (gateDone) begin
                rangeGate <= rangeGate + `DROB_RANGE_BITS'(1);
            end
        end
    end

    drob_pkg::drob_report_s report;
    drob_pkg::drob_header_s header;

    assign report = '{spare: '0, velocity: filterNum, range: rangeGate,
                      strength: delayedMagnitude};
    assign header = '{spare: '0, lossStatus: {lateStatus, overflowStatus}, prf: prf,
                      azimuth: azimuth};

    ////////////////////////////////////////////////////////////////////////////////
    // Input shift register; entry 0 is the capture stage.

    logic [`DROB_WORD_BITS-1:0] inReg [DEPTH];
    logic [5:0] inCount;
    wire logic inFull = (inCount >= 6'(MAX_WORDS));
    wire logic loadReport = thresholdCrossingStrobe && !intervalStart && !inFull;
    wire logic lostReport = thresholdCrossingStrobe && !intervalStart && inFull;
    wire logic loadAny = intervalStart || loadReport;

    // shift on each load; runs regardless of the drain.
    always_ff @(posedge clock) begin
        if (loadAny) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                inReg[i] <= inReg[i - 1];
            end
            inReg[0] <= intervalStart ? `DROB_WORD_BITS'(header) : `DROB_WORD_BITS'(report);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            inCount <= 6'h00;
        end else if (intervalStart) begin
            inCount <= 6'h01;
        end else if (loadReport) begin
            inCount <= inCount + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Loss status; a new event in the capture cycle wins over the clear.

    logic [5:0] outCount;
    wire logic lateEvent = intervalEnd && (draining || outCount != 6'h00);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            overflowStatus <= 1'b0;
            lateStatus <= 1'b0;
        end else begin
            overflowStatus <= lostReport || (overflowStatus && !intervalStart);
            lateStatus <= lateEvent || (lateStatus && !intervalStart);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output register and drain handshake.

    logic xferTick;

    drob_rate_div #(
        .DIV(XFER_DIV)
    ) rateDiv (
        .clock(clock),
        .rst_b(rst_b),
        .tick(xferTick)
    );

    logic [`DROB_WORD_BITS-1:0] outReg [DEPTH];
    logic [5:0] alignLeft;
    drob_pkg::drob_drain_e state;
    drob_pkg::drob_drain_e next_state;
    wire logic shiftOut = (state == drob_pkg::DROB_ALIGN && xferTick && alignLeft != 6'h00)
                          || (state == drob_pkg::DROB_WAIT && ackRise);

    // A late interval overwrites what is still waiting; the lost words are flagged, not kept.
    always_ff @(posedge clock) begin
        if (intervalEnd) begin
            outReg <= inReg;
        end else if (shiftOut) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                outReg[i] <= outReg[i - 1];
            end
            outReg[0] <= '0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            drob_pkg::DROB_IDLE: next_state = drob_pkg::DROB_IDLE;
            drob_pkg::DROB_ALIGN: if (alignLeft == 6'h00) next_state = drob_pkg::DROB_OFFER;
            drob_pkg::DROB_OFFER: next_state = drob_pkg::DROB_WAIT;
            drob_pkg::DROB_WAIT: begin
                if (ackRise) begin
                    next_state = (outCount == 6'h01) ? drob_pkg::DROB_IDLE
                                                     : drob_pkg::DROB_OFFER;
                end
            end
        endcase
        if (intervalEnd) begin
            next_state = drob_pkg::DROB_ALIGN;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= drob_pkg::DROB_IDLE;
            outCount <= 6'h00;
            alignLeft <= 6'h00;
        end else begin
            state <= next_state;
            if (intervalEnd) begin
                outCount <= inCount;
                alignLeft <= 6'(DEPTH) - inCount;
            end else begin
                if (shiftOut && state == drob_pkg::DROB_ALIGN) begin
                    alignLeft <= alignLeft - 6'h01;
                end
                if (shiftOut && state == drob_pkg::DROB_WAIT) begin
                    outCount <= outCount - 6'h01;
                end
            end
        end
    end

    // Request pulse and data both leave from flops; the test port mirrors them.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            outputWord <= '0;
            testWord <= '0;
            inputDataRequest <= 1'b0;
            testDataRequest <= 1'b0;
            draining <= 1'b0;
        end else begin
            outputWord <= outReg[DEPTH - 1];
            testWord <= outReg[DEPTH - 1];
            inputDataRequest <= (state == drob_pkg::DROB_OFFER) && !intervalEnd;
            testDataRequest <= (state == drob_pkg::DROB_OFFER) && !intervalEnd;
            draining <= (next_state != drob_pkg::DROB_IDLE);
        end
    end

endmodule

// ===== drob_props.sv
// Concurrent checks on the report output buffer ports.
// Assumes one clock domain and the port names of drob_buffer.
`include "drob_map.svh"
module drob_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic intervalStart,
    input wire logic intervalEnd,
    input wire logic thresholdCrossingStrobe,
    input wire logic processorAck,
    input wire logic testAck,
    input wire logic ackFromTest,
    input wire logic [`DROB_WORD_BITS-1:0] outputWord,
    input wire logic inputDataRequest,
    input wire logic testDataRequest,
    input wire logic overflowStatus,
    input wire logic lateStatus,
    input wire logic draining
);
    // The acknowledge that the drain should obey; the other source is ignored.
    wire selAck = ackFromTest ? testAck : processorAck;
    // Marks a word offered and not yet acknowledged; a new interval end drops the offer.
    logic offered;
    always_ff @(posedge clock) begin
        if (!rst_b || intervalEnd) begin
            offered <= 1'b0;
        end else if (inputDataRequest) begin
            offered <= 1'b1;
        end else if ($rose(selAck)) begin
            offered <= 1'b0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    AST_REQ_PULSE: assert property (inputDataRequest |=> !inputDataRequest[*3])
        else $error("request is not a lone pulse");
    AST_REQ_DRAIN: assert property (inputDataRequest |-> draining)
        else $error("request outside a drain");
    AST_TEST_REQ: assert property (testDataRequest == inputDataRequest)
        else $error("test request differs");
    // A new interval end may legally replace the offered word, so it is left out here.
    AST_WORD_HOLD: assert property (inputDataRequest && !intervalEnd ##1 !intervalEnd |->
        $stable(outputWord) ##1 $stable(outputWord))
        else $error("word moved before acknowledge");
    // Only an acknowledge of an offered word must bring the next request.
    AST_ACK_NEXT: assert property ($rose(selAck) && offered |->
        ##[1:12] (inputDataRequest || !draining || intervalEnd))
        else $error("no new request after acknowledge");
    AST_LATE_SET: assert property (intervalEnd && draining |=> lateStatus)
        else $error("late status not set");
    AST_OVF_HOLD: assert property (overflowStatus && !intervalStart |=> overflowStatus)
        else $error("overflow status dropped");
    AST_CLEAR: assert property (intervalStart && !intervalEnd && !thresholdCrossingStrobe
        |=> !lateStatus && !overflowStatus)
        else $error("status not cleared by header");
    // Main scenarios reached.
    cover property (overflowStatus);
    cover property (lateStatus);
    cover property ($rose(testAck) && ackFromTest && draining);
endmodule
bind drob_buffer drob_props chk (
    .clock(clock),
    .rst_b(rst_b),
    .intervalStart(intervalStart),
    .intervalEnd(intervalEnd),
    .thresholdCrossingStrobe(thresholdCrossingStrobe),
    .processorAck(processorAck),
    .testAck(testAck),
    .ackFromTest(ackFromTest),
    .outputWord(outputWord),
    .inputDataRequest(inputDataRequest),
    .testDataRequest(testDataRequest),
    .overflowStatus(overflowStatus),
    .lateStatus(lateStatus),
    .draining(draining)
);

// ===== drob_proc_model.sv
// Behavioural computer that takes offered words and acknowledges them.
// Assumes one-cycle request pulses on the shared clock.
module drob_proc_model #(
    parameter int DELAY = 0
) (
    input wire logic clock,
    input wire logic req,
    input wire logic [31:0] word,
    input wire logic stall,
    output logic ack
);
    logic [31:0] got[$];
    bit pend;
    // A stalled model still records words, so a late drain can be seen.
    initial begin
        ack = 1'b0;
        pend = 1'b0;
        forever begin
            @(posedge clock);
            if (req) begin
                got.push_back(word);
                pend = 1'b1;
            end
            if (pend && !stall) begin
                pend = 1'b0;
                repeat (DELAY) @(posedge clock);
                ack <= 1'b1;
                repeat (2) @(posedge clock);
                ack <= 1'b0;
            end
        end
    end
endmodule

// ===== tb_top.sv
// Self-checking bench for the report output buffer.
// Assumes two computer models; the processor answers fast, the test computer slowly.
`include "drob_map.svh"
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_b, intervalStart, intervalEnd, filterTick, thresholdCrossingStrobe;
    logic ackFromTest, processorAck, testAck, inputDataRequest, testDataRequest;
    logic overflowStatus, lateStatus, draining, procStall, testStall;
    logic [11:0] azimuth;
    logic [1:0] prf;
    logic [15:0] delayedMagnitude;
    logic [31:0] outputWord, testWord;
    logic [31:0] exp[$];
    int failures, nCompared;
    // A short transfer divider keeps alignment brief.
    drob_buffer #(.XFER_DIV(4)) dut (
        .clock(clock),
        .rst_b(rst_b),
        .intervalStart(intervalStart),
        .intervalEnd(intervalEnd),
        .azimuth(azimuth),
        .prf(prf),
        .filterTick(filterTick),
        .delayedMagnitude(delayedMagnitude),
        .thresholdCrossingStrobe(thresholdCrossingStrobe),
        .processorAck(processorAck),
        .testAck(testAck),
        .ackFromTest(ackFromTest),
        .outputWord(outputWord),
        .inputDataRequest(inputDataRequest),
        .testWord(testWord),
        .testDataRequest(testDataRequest),
        .overflowStatus(overflowStatus),
        .lateStatus(lateStatus),
        .draining(draining)
    );
    drob_proc_model #(.DELAY(0)) proc (.clock(clock), .req(inputDataRequest),
        .word(outputWord), .stall(procStall), .ack(processorAck));
    drob_proc_model #(.DELAY(9)) tstm (.clock(clock), .req(testDataRequest),
        .word(testWord), .stall(testStall), .ack(testAck));
    // Clock at 250 MHz.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task completeRun();
        $display("compared %0d, failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A low cycle after each pulse keeps two pulses of one strobe apart.
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        @(negedge clock);
    endtask
    // One interval; ticks are padded to whole gates so the filter count restarts at 0.
    task automatic interval(input int nRep, input logic [11:0] az, input logic [1:0] lost);
        exp.delete();
        azimuth = az;
        prf = az[1:0];
        exp.push_back({16'h0000, lost, az[1:0], az});
        pulse(intervalStart);
        for (int k = 0; k < nRep; k++) begin
            delayedMagnitude = 16'h1000 + 16'(k);
            pulse(thresholdCrossingStrobe);
            if (k < 38) exp.push_back({3'h0, 3'(k), 10'(k / 8), delayedMagnitude});
            pulse(filterTick);
        end
        repeat ((8 - nRep % 8) % 8) pulse(filterTick);
        pulse(intervalEnd);
    endtask
    task automatic settle();
        int t;
        t = 0;
        while ((draining !== 1'b0 || t < 3) && t < 20000) begin
            @(negedge clock);
            t++;
        end
        if (t >= 20000) begin
            failures++;
            completeRun();
        end
    endtask
    task automatic compare();
        `CHK("words", exp.size(), proc.got.size())
        `CHK("testWords", exp.size(), tstm.got.size())
        for (int i = 0; i < exp.size() && i < proc.got.size() && i < tstm.got.size(); i++) begin
            `CHK("word", exp[i], proc.got[i])
            `CHK("testWord", exp[i], tstm.got[i])
        end
        proc.got.delete();
        tstm.got.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic scenNormal();
        interval(3, 12'hA5C, 2'h0);
        settle();
        compare();
    endtask
    task automatic scenOverflow();
        interval(40, 12'h3F1, 2'h0);
        `CHK("overflowStatus", 1'b1, overflowStatus)
        settle();
        compare();
        interval(1, 12'h002, 2'h1);
        `CHK("overflowCleared", 1'b0, overflowStatus)
        settle();
        compare();
    endtask
    // The first interval is acknowledged only after the next has overwritten it.
    task automatic scenLate();
        logic [31:0] first;
        int t;
        procStall = 1'b1;
        interval(2, 12'h7E4, 2'h0);
        first = exp[0];
        t = 0;
        while (proc.got.size() == 0 && t < 2000) begin
            @(negedge clock);
            t++;
        end
        if (t >= 2000) begin
            failures++;
            completeRun();
        end
        interval(5, 12'h155, 2'h0);
        `CHK("lateStatus", 1'b1, lateStatus)
        exp.push_front(first);
        procStall = 1'b0;
        settle();
        compare();
    endtask
    // The processor keeps acknowledging here; the drain must follow the slow test computer.
    task automatic scenTestSource();
        procStall = 1'b0;
        testStall = 1'b0;
        ackFromTest = 1'b1;
        repeat (4) @(negedge clock);
        interval(4, 12'hC38, 2'h2);
        `CHK("lateCleared", 1'b0, lateStatus)
        settle();
        compare();
    endtask
    // Main sequence.
    initial begin
        rst_b = 1'b0;
        intervalStart = 1'b0;
        intervalEnd = 1'b0;
        filterTick = 1'b0;
        thresholdCrossingStrobe = 1'b0;
        ackFromTest = 1'b0;
        azimuth = 12'h000;
        prf = 2'h0;
        delayedMagnitude = 16'h0000;
        procStall = 1'b0;
        testStall = 1'b1;
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        scenNormal();
        scenOverflow();
        scenLate();
        scenTestSource();
        completeRun();
    end
endmodule
